/* File: hdl/gp_port.sv */
// Eight-pin general purpose port with sensing and two interrupts.
// Assumes one clock, synchronous reset, Avalon-MM register access;
// pads and pad-side pulls are resolved outside this module.
//
// Implementation choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - Eight pins, 0 to 7, each individually input or output.
// - Input inversion flips pad value before the readable pin value.
// - Output inversion flips output register value before the pad.
// - Inversion also applies to alternate-function drive and sampling.
// - Bus-keeper weakly holds last pad level, up after 1, down after 0.
// - Per-pin drive: totem, pull-up, pull-down, wired-AND, wired-OR, keeper.
// - Sensing synchronous with port clock running, otherwise asynchronous; here always sampled on clk, port_clk_on only gates wake.
// - Inversion applied before edge or level detection.
// - Every sense configuration can raise an asynchronous wake request.
// - Two interrupt outputs, each with its own priority level.
// - Each interrupt has its own per-pin source mask.
// - Interrupt raised when an unmasked pin meets its sense condition.
// - Toggle, clear and set locations for output and direction.
// - One configuration write may configure several selected pins.
// - Event channel 0 may be routed out on pin 7.
// - A clock signal may be driven out on a port pin.
// - Enabled alternate function takes the pin over from port registers; here the CTRL clock and event outputs on pin 7 still win over it.
// - Port registers mirrored as virtual port words for single-bit access.
// - Any reset puts all pins in high impedance immediately; here the reset is synchronous and takes effect at the next clock edge.
module gp_port #(
  parameter int NPINS = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input wire logic [gp_pkg::GP_AW-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [gp_pkg::GP_DW-1:0] writedata,
  output logic [gp_pkg::GP_DW-1:0] readdata,
  output logic waitrequest,
  // Pads
  input wire logic [NPINS-1:0] pad_i,
  output logic [NPINS-1:0] pad_o,
  output logic [NPINS-1:0] pad_oe_n,
  output logic [NPINS-1:0] pull_up,
  output logic [NPINS-1:0] pull_dn,
  // Alternate functions and system
  input wire logic [NPINS-1:0] alt_en,
  input wire logic [NPINS-1:0] alt_o,
  input wire logic [NPINS-1:0] alt_oe,
  output logic [NPINS-1:0] alt_i,
  input wire logic ev0_i,
  input wire logic port_clk_on,
  // Interrupts and wake
  output logic irq0,
  output logic irq1,
  output logic [1:0] irq0_lvl,
  output logic [1:0] irq1_lvl,
  output logic wake
);
  import gp_pkg::*;

  logic [NPINS-1:0] dir_q, out_q, m0_q, m1_q, mpc_q;
  logic [3:0] intctrl_q;
  logic [1:0] flags_q, ctrl_q;
  logic [GP_CFG_W-1:0] cfg_q [NPINS];
  logic [NPINS-1:0] s1_q, s2_q, vprev_q, hit;
  logic [NPINS-1:0] v_in, inv;
  logic [NPINS-1:0] po_d, oen_d, pu_d, pd_d;
  logic wait_q, wr_ok, clk_div_q, wake_q, irq0_q, irq1_q;
  logic [GP_DW-1:0] rd_q, rd_d;
  logic [7:0] wb;

  assign wb = writedata[7:0];
  // Write takes effect only at the edge where waitrequest is low
  assign wr_ok = write && !wait_q;

  // One wait state per access, answer registered
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !((read || write) && wait_q);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_q <= GP_RD_ZERO;
    end else if (read && wait_q) begin
      rd_q <= rd_d;
    end
  end

  always_comb begin
    rd_d = GP_RD_ZERO;
    unique case (address)
      GP_DIR, GP_VDIR: rd_d[7:0] = dir_q;
      GP_OUT, GP_VOUT: rd_d[7:0] = out_q;
      GP_IN, GP_VIN: rd_d[7:0] = v_in;
      GP_INTCTRL: rd_d[3:0] = intctrl_q;
      GP_INT0MASK: rd_d[7:0] = m0_q;
      GP_INT1MASK: rd_d[7:0] = m1_q;
      GP_INTFLAGS, GP_VFLAGS: rd_d[1:0] = flags_q;
      GP_MPCMASK: rd_d[7:0] = mpc_q;
      GP_CTRL: rd_d[1:0] = ctrl_q;
      default: begin
        for (int i = 0; i < NPINS; i++) begin
          if (address == GP_PINCFG0 + 8'(4 * i)) begin
            rd_d[GP_CFG_W-1:0] = cfg_q[i];
          end
        end
      end
    endcase
  end

  // Direction with set, clear and toggle aliases
  always_ff @(posedge clk) begin
    if (rst) begin
      dir_q <= GP_RST_BYTE;
    end else if (wr_ok) begin
      unique case (address)
        GP_DIR, GP_VDIR: dir_q <= wb;
        GP_DIRSET: dir_q <= dir_q | wb;
        GP_DIRCLR: dir_q <= dir_q & ~wb;
        GP_DIRTGL: dir_q <= dir_q ^ wb;
        default: dir_q <= dir_q;
      endcase
    end
  end

  // Output value with set, clear and toggle aliases
  always_ff @(posedge clk) begin
    if (rst) begin
      out_q <= GP_RST_BYTE;
    end else if (wr_ok) begin
      unique case (address)
        GP_OUT, GP_VOUT: out_q <= wb;
        GP_OUTSET: out_q <= out_q | wb;
        GP_OUTCLR: out_q <= out_q & ~wb;
        GP_OUTTGL: out_q <= out_q ^ wb;
        default: out_q <= out_q;
      endcase
    end
  end

  // Masks, priorities and control
  always_ff @(posedge clk) begin
    if (rst) begin
      m0_q <= GP_RST_BYTE;
      m1_q <= GP_RST_BYTE;
      mpc_q <= GP_RST_BYTE;
      intctrl_q <= 4'h0;
      ctrl_q <= 2'h0;
    end else if (wr_ok) begin
      if (address == GP_INT0MASK) m0_q <= wb;
      if (address == GP_INT1MASK) m1_q <= wb;
      if (address == GP_MPCMASK) mpc_q <= wb;
      if (address == GP_INTCTRL) intctrl_q <= wb[3:0];
      if (address == GP_CTRL) ctrl_q <= wb[1:0];
    end
  end

  // Pin configuration, single or several pins per write
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NPINS; i++) cfg_q[i] <= GP_RST_CFG;
    end else if (wr_ok) begin
      for (int i = 0; i < NPINS; i++) begin
        if (address == GP_PINCFG0 + 8'(4 * i)) begin
          cfg_q[i] <= writedata[GP_CFG_W-1:0];
        end else if (address == GP_PINCFG_MULTI && mpc_q[i]) begin
          cfg_q[i] <= writedata[GP_CFG_W-1:0];
        end
      end
    end
  end

  // Pad synchroniser and sense history
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= GP_RST_BYTE;
      s2_q <= GP_RST_BYTE;
      vprev_q <= GP_RST_BYTE;
    end else begin
      s1_q <= pad_i;
      s2_q <= s1_q;
      vprev_q <= v_in;
    end
  end

  // Clock out runs at half the port clock
  always_ff @(posedge clk) begin
    if (rst) begin
      clk_div_q <= 1'b0;
    end else begin
      clk_div_q <= !clk_div_q;
    end
  end

  // Per-pin sensing and drive
  for (genvar p = 0; p < NPINS; p++) begin : g_pin
    gp_sense_type sn;
    gp_drive_type dv;
    logic val, en, v;
    assign sn = gp_sense_type'(cfg_q[p][GP_SENSE_LSB +: 2]);
    assign dv = gp_drive_type'(cfg_q[p][GP_DRV_LSB +: 3]);
    assign inv[p] = cfg_q[p][GP_INV_BIT];
    assign v_in[p] = s2_q[p] ^ inv[p];

    always_comb begin
      unique case (sn)
        GP_SENSE_BOTH: hit[p] = v_in[p] ^ vprev_q[p];
        GP_SENSE_RISE: hit[p] = v_in[p] && !vprev_q[p];
        GP_SENSE_FALL: hit[p] = !v_in[p] && vprev_q[p];
        GP_SENSE_LOW: hit[p] = !v_in[p];
      endcase
    end

    always_comb begin
      if (p == GP_SPECIAL_PIN && ctrl_q[GP_CTRL_CLKOUT]) begin
        val = clk_div_q;
        en = 1'b1;
      end else if (p == GP_SPECIAL_PIN && ctrl_q[GP_CTRL_EVOUT]) begin
        val = ev0_i;
        en = 1'b1;
      end else if (alt_en[p]) begin
        val = alt_o[p];
        en = alt_oe[p];
      end else begin
        val = out_q[p];
        en = dir_q[p];
      end
      v = val ^ inv[p];
      po_d[p] = v;
      oen_d[p] = !en;
      pu_d[p] = 1'b0;
      pd_d[p] = 1'b0;
      unique case (dv)
        GP_DRV_PUP: pu_d[p] = !en;
        GP_DRV_PDN: pd_d[p] = !en;
        GP_DRV_KEEP: begin
          pu_d[p] = !en && s2_q[p];
          pd_d[p] = !en && !s2_q[p];
        end
        GP_DRV_WOR: begin
          oen_d[p] = !(en && v);
          pd_d[p] = !(en && v);
        end
        GP_DRV_WAND: begin
          oen_d[p] = !(en && !v);
          pu_d[p] = !(en && !v);
        end
        default: begin
          oen_d[p] = !en;
        end
      endcase
    end

    // Keeper must follow the synchronised level, never the raw pad
    a_keep_pull: assert property (@(posedge clk) disable iff (rst)
      dv == GP_DRV_KEEP && !en |=> pull_up[p] == $past(s2_q[p]) && pull_dn[p] == !$past(s2_q[p]))
      else $error("bus keeper level wrong");
    // Wired-OR may only ever drive a one
    a_wor_release: assert property (@(posedge clk) disable iff (rst)
      dv == GP_DRV_WOR && !v |=> pad_oe_n[p] && pull_dn[p])
      else $error("wired-OR drove a low");
  end

  // Pad outputs, released to high impedance by reset
  always_ff @(posedge clk) begin
    if (rst) begin
      pad_o <= GP_RST_BYTE;
      pad_oe_n <= ~GP_RST_BYTE;
      pull_up <= GP_RST_BYTE;
      pull_dn <= GP_RST_BYTE;
      alt_i <= GP_RST_BYTE;
    end else begin
      pad_o <= po_d;
      pad_oe_n <= oen_d;
      pull_up <= pu_d;
      pull_dn <= pd_d;
      alt_i <= v_in;
    end
  end

  // Sticky flags; a new hit beats a same-cycle clear
  always_ff @(posedge clk) begin
    if (rst) begin
      flags_q <= 2'h0;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (|(hit & (k == 0 ? m0_q : m1_q))) begin
          flags_q[k] <= 1'b1;
        end else if (wr_ok && (address == GP_INTFLAGS || address == GP_VFLAGS)
                     && wb[k]) begin
          flags_q[k] <= 1'b0;
        end
      end
    end
  end

  // Level zero means the interrupt is off
  always_ff @(posedge clk) begin
    if (rst) begin
      irq0_q <= 1'b0;
      irq1_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      irq0_q <= flags_q[0] && (intctrl_q[1:0] != 2'h0);
      irq1_q <= flags_q[1] && (intctrl_q[3:2] != 2'h0);
      // Clock stopped: the hit is carried out as a wake request
      wake_q <= !port_clk_on && |(hit & (m0_q | m1_q));
    end
  end

  always_comb begin
    readdata = rd_q;
    waitrequest = wait_q;
    irq0 = irq0_q;
    irq1 = irq1_q;
    irq0_lvl = intctrl_q[1:0];
    irq1_lvl = intctrl_q[3:2];
    wake = wake_q;
  end

  a_wait_one: assert property (@(posedge clk) disable iff (rst)
    (read || write) && wait_q |=> !wait_q ##1 wait_q)
    else $error("waitrequest not a single low cycle");
  a_dirset_ok: assert property (@(posedge clk) disable iff (rst)
    wr_ok && address == GP_DIRSET |=> dir_q == ($past(dir_q) | $past(wb)))
    else $error("direction set wrong");
  a_outclr_ok: assert property (@(posedge clk) disable iff (rst)
    wr_ok && address == GP_OUTCLR |=> out_q == ($past(out_q) & ~$past(wb)))
    else $error("output clear wrong");
  a_outtgl_ok: assert property (@(posedge clk) disable iff (rst)
    wr_ok && address == GP_OUTTGL |=> out_q == ($past(out_q) ^ $past(wb)))
    else $error("output toggle wrong");
  a_sync_two: assert property (@(posedge clk) disable iff (rst)
    1'b1 |-> ##2 s2_q == $past(pad_i, 2))
    else $error("synchroniser depth wrong");
  a_flag_set: assert property (@(posedge clk) disable iff (rst)
    |(hit & m0_q) |=> flags_q[0] ##1 irq0 || intctrl_q[1:0] == 2'h0)
    else $error("interrupt 0 not raised");
  a_rst_hiz: assert property (@(posedge clk)
    rst |=> pad_oe_n == 8'hff)
    else $error("pins not released in reset");
  a_in_inv: assert property (@(posedge clk) disable iff (rst)
    read && wait_q && address == GP_IN |=> readdata[7:0] == $past(s2_q ^ inv))
    else $error("pin value not inverted");
  a_wake_async: assert property (@(posedge clk) disable iff (rst)
    !port_clk_on && |(hit & m1_q) |=> wake)
    else $error("wake missing");
  a_multi_cfg: assert property (@(posedge clk) disable iff (rst)
    wr_ok && address == GP_PINCFG_MULTI && mpc_q[0]
    |=> cfg_q[0] == $past(writedata[GP_CFG_W-1:0]))
    else $error("multi-pin configuration missed");
  // Pin 7 routing: event level, or a clock that flips every edge
  a_ev_out: assert property (@(posedge clk) disable iff (rst)
    ctrl_q[GP_CTRL_EVOUT] && !ctrl_q[GP_CTRL_CLKOUT]
    |=> pad_o[GP_SPECIAL_PIN] == $past(ev0_i ^ inv[GP_SPECIAL_PIN]))
    else $error("event output on pin 7 wrong");
  a_clk_out: assert property (@(posedge clk) disable iff (rst)
    ctrl_q[GP_CTRL_CLKOUT] && $stable(ctrl_q) && $stable(inv)
    |=> pad_o[GP_SPECIAL_PIN] != $past(pad_o[GP_SPECIAL_PIN]))
    else $error("clock output on pin 7 not toggling");
  c_irq1: cover property (@(posedge clk) disable iff (rst) irq1);
  c_wake: cover property (@(posedge clk) disable iff (rst) wake);
  c_clk_out: cover property (@(posedge clk) disable iff (rst)
    ctrl_q[GP_CTRL_CLKOUT] ##1 ctrl_q[GP_CTRL_CLKOUT]);
  c_keeper: cover property (@(posedge clk) disable iff (rst)
    pull_up != 8'h00 && pull_dn != 8'h00);
  c_multi: cover property (@(posedge clk) disable iff (rst)
    wr_ok && address == GP_PINCFG_MULTI && mpc_q != 8'h00);
endmodule : gp_port

`default_nettype wire

/* File: shared/gp_pkg.sv */
// Constants for the eight-pin general purpose port.
// Assumes a 32-bit Avalon-MM slave, one word per register.
package gp_pkg;
  localparam int GP_AW = 8;
  localparam int GP_DW = 32;
  // Register byte offsets
  localparam logic [7:0] GP_DIR = 8'h00;
  localparam logic [7:0] GP_DIRSET = 8'h04;
  localparam logic [7:0] GP_DIRCLR = 8'h08;
  localparam logic [7:0] GP_DIRTGL = 8'h0c;
  localparam logic [7:0] GP_OUT = 8'h10;
  localparam logic [7:0] GP_OUTSET = 8'h14;
  localparam logic [7:0] GP_OUTCLR = 8'h18;
  localparam logic [7:0] GP_OUTTGL = 8'h1c;
  localparam logic [7:0] GP_IN = 8'h20;
  localparam logic [7:0] GP_INTCTRL = 8'h24;
  localparam logic [7:0] GP_INT0MASK = 8'h28;
  localparam logic [7:0] GP_INT1MASK = 8'h2c;
  localparam logic [7:0] GP_INTFLAGS = 8'h30;
  localparam logic [7:0] GP_MPCMASK = 8'h34;
  localparam logic [7:0] GP_PINCFG_MULTI = 8'h38;
  localparam logic [7:0] GP_CTRL = 8'h3c;
  localparam logic [7:0] GP_PINCFG0 = 8'h40;
  localparam logic [7:0] GP_VDIR = 8'h80;
  localparam logic [7:0] GP_VOUT = 8'h84;
  localparam logic [7:0] GP_VIN = 8'h88;
  localparam logic [7:0] GP_VFLAGS = 8'h8c;
  // Pin configuration fields
  localparam int GP_SENSE_LSB = 0;
  localparam int GP_DRV_LSB = 2;
  localparam int GP_INV_BIT = 5;
  localparam int GP_CFG_W = 6;
  // Control register bits
  localparam int GP_CTRL_EVOUT = 0;
  localparam int GP_CTRL_CLKOUT = 1;
  localparam int GP_SPECIAL_PIN = 7;
  // Reset values
  localparam logic [7:0] GP_RST_BYTE = 8'h00;
  localparam logic [5:0] GP_RST_CFG = 6'h00;
  localparam logic [31:0] GP_RD_ZERO = 32'h0000_0000;
  typedef enum logic [1:0] {
    GP_SENSE_BOTH = 2'h0,
    GP_SENSE_RISE = 2'h1,
    GP_SENSE_FALL = 2'h2,
    GP_SENSE_LOW = 2'h3
  } gp_sense_type;
  typedef enum logic [2:0] {
    GP_DRV_TOTEM = 3'h0,
    GP_DRV_KEEP = 3'h1,
    GP_DRV_PDN = 3'h2,
    GP_DRV_PUP = 3'h3,
    GP_DRV_WOR = 3'h4,
    GP_DRV_WAND = 3'h5
  } gp_drive_type;
endpackage : gp_pkg

/* File: verif/gp_pad_model.sv */
// Pad model for the eight port pins: external drivers, pulls and a floating pad.
// Assumes the port drives pad_o wherever pad_oe_n is low.
`timescale 1ns/1ns
`default_nettype none
module gp_pad_model (
  // Clock
  input wire logic clk,
  // Port side
  input wire logic [7:0] pad_o,
  input wire logic [7:0] pad_oe_n,
  input wire logic [7:0] pull_up,
  input wire logic [7:0] pull_dn,
  // External drivers
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  // Resolved pad level
  output logic [7:0] pad_i
);
  logic [7:0] last_q;
  always_ff @(posedge clk) begin
    last_q <= pad_i;
  end
  // Undriven and unpulled pad flips so a stale level is never read as valid
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pad_oe_n[i]) pad_i[i] = pad_o[i];
      else if (ext_en[i]) pad_i[i] = ext_val[i];
      else if (pull_up[i]) pad_i[i] = 1'b1;
      else if (pull_dn[i]) pad_i[i] = 1'b0;
      else pad_i[i] = ~last_q[i];
    end
  end
endmodule : gp_pad_model
`default_nettype wire

/* File: verif/gp_port_bench.sv */
// Self-checking bench for the general purpose port.
// Assumes the pad model in its own file; one 100 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module gp_port_bench;
  import gp_pkg::*;
  logic clk, rst, read, write, ev0_i, port_clk_on, irq0, irq1, wake, waitrequest;
  logic [7:0] address, pad_i, pad_o, pad_oe_n, pull_up, pull_dn, alt_en, alt_o, alt_oe, alt_i;
  logic [7:0] ext_en, ext_val, mdir, mout, m, v, inv;
  logic [31:0] writedata, readdata, q, seed;
  logic [1:0] irq0_lvl, irq1_lvl, op;
  logic exp;
  int bad_count = 0;
  int cmp_count = 0;
  logic [7:0] rst_adr [5] = '{GP_DIR, GP_OUT, GP_INTCTRL, GP_INT0MASK, GP_CTRL};
  gp_port gp_port_inst (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .pad_i(pad_i),
    .pad_o(pad_o), .pad_oe_n(pad_oe_n), .pull_up(pull_up), .pull_dn(pull_dn), .alt_en(alt_en),
    .alt_o(alt_o), .alt_oe(alt_oe), .alt_i(alt_i), .ev0_i(ev0_i), .port_clk_on(port_clk_on),
    .irq0(irq0), .irq1(irq1), .irq0_lvl(irq0_lvl), .irq1_lvl(irq1_lvl), .wake(wake));
  gp_pad_model gp_pad_model_inst (.clk(clk), .pad_o(pad_o), .pad_oe_n(pad_oe_n), .pull_up(pull_up),
    .pull_dn(pull_dn), .ext_en(ext_en), .ext_val(ext_val), .pad_i(pad_i));
  always #5 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction : lfsr
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= !w;
    write <= w;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) bad_count++;
    r = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task automatic settle();
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask : settle
  task automatic setp(input logic [7:0] p);
    @(posedge clk);
    ext_val <= p;
    settle();
  endtask : setp
  initial begin
    #400000;
    bad_count++;
    results();
  end
  initial begin
    clk = 0; rst = 1; address = 0; read = 0; write = 0; writedata = 0; ev0_i = 0; port_clk_on = 1;
    alt_en = 0; alt_o = 0; alt_oe = 0; ext_en = 8'hff; ext_val = 0; seed = 32'hae0befdf;
    mdir = 0; mout = 0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    chk("oe_in_reset", 32'hff, pad_oe_n);
    @(posedge clk);
    rst <= 0;
    foreach (rst_adr[i]) begin
      bus(1'b0, rst_adr[i], 0, q);
      chk("reset_value", 0, q);
    end
    for (int k = 0; k < 16; k++) begin
      seed = lfsr(seed);
      m = seed[7:0];
      op = seed[9:8];
      v = seed[10] ? mout : mdir;
      wr((seed[10] ? GP_OUT : GP_DIR) + {4'h0, op, 2'b00}, {24'h0, m});
      case (op)
        2'd0: v = m;
        2'd1: v = v | m;
        2'd2: v = v & ~m;
        default: v = v ^ m;
      endcase
      if (seed[10]) mout = v;
      else mdir = v;
    end
    bus(1'b0, GP_DIR, 0, q);
    chk("dir", {24'h0, mdir}, q);
    bus(1'b0, GP_OUT, 0, q);
    chk("out", {24'h0, mout}, q);
    bus(1'b0, GP_VDIR, 0, q);
    chk("vdir", {24'h0, mdir}, q);
    bus(1'b0, GP_VOUT, 0, q);
    chk("vout", {24'h0, mout}, q);
    settle();
    chk("pad_oe_n", {24'h0, ~mdir}, pad_oe_n);
    chk("pad_o", {24'h0, mout}, pad_o);
    seed = lfsr(seed);
    inv = seed[7:0];
    wr(GP_MPCMASK, {24'h0, inv});
    wr(GP_PINCFG_MULTI, 32'h20);
    settle();
    chk("pad_o_inv", {24'h0, mout ^ inv}, pad_o);
    wr(GP_DIR, 0);
    setp(seed[15:8]);
    bus(1'b0, GP_IN, 0, q);
    chk("in_inv", {24'h0, seed[15:8] ^ inv}, q);
    bus(1'b0, GP_VIN, 0, q);
    chk("vin", {24'h0, seed[15:8] ^ inv}, q);
    wr(GP_MPCMASK, 32'hff);
    wr(GP_PINCFG_MULTI, 0);
    wr(GP_INTCTRL, 1);
    wr(GP_INT0MASK, 1);
    wr(GP_INT1MASK, 0);
    // Case 4 is rise sense with inversion, so a pad fall must hit
    for (int s = 0; s < 5; s++) begin
      wr(GP_PINCFG0, s == 4 ? 32'h21 : s);
      for (int ph = 0; ph < 2; ph++) begin
        setp(ph ? 8'h00 : 8'h01);
        wr(GP_INTFLAGS, 32'hff);
        setp(ph ? 8'h01 : 8'h00);
        // Low sense keeps re-setting while the pad sat low before the rise
        exp = ph ? (s == 0 || s == 1 || s == 3) : (s != 1);
        bus(1'b0, GP_INTFLAGS, 0, q);
        chk("flags", {31'h0, exp}, q & 32'h3);
        chk("irq0", {31'h0, exp}, irq0);
        chk("irq1", 0, irq1);
      end
    end
    chk("irq0_lvl", 1, irq0_lvl);
    // Second interrupt on pin 0, first one switched off
    wr(GP_INT0MASK, 0);
    wr(GP_INT1MASK, 1);
    wr(GP_INTCTRL, 32'h4);
    wr(GP_PINCFG0, 1);
    setp(8'h00);
    wr(GP_INTFLAGS, 32'hff);
    setp(8'h01);
    chk("irq1_on", 1, irq1);
    chk("irq0_off", 0, irq0);
    chk("irq0_lvl_off", 0, irq0_lvl);
    chk("irq1_lvl", 1, irq1_lvl);
    // Port clock stopped: a low level must raise wake
    wr(GP_PINCFG0, 3);
    @(posedge clk);
    port_clk_on <= 1'b0;
    setp(8'h00);
    chk("wake", 1, wake);
    @(posedge clk);
    port_clk_on <= 1'b1;
    settle();
    chk("wake_off", 0, wake);
    @(posedge clk);
    alt_en <= 8'h02;
    alt_o <= 8'h02;
    alt_oe <= 8'h02;
    settle();
    chk("alt_pad_o", 1, pad_o[1]);
    chk("alt_pad_oe_n", 0, pad_oe_n[1]);
    chk("alt_i", {31'h0, ext_val[0]}, alt_i[0]);
    // Pin 2 left to the port alone: pulls, keeper and wired drive
    wr(GP_PINCFG0 + 8'h08, 32'h0c);
    @(posedge clk);
    ext_en <= 8'hfb;
    settle();
    chk("pull_up", 1, pull_up[2]);
    chk("pull_up_pad", 1, pad_i[2]);
    wr(GP_PINCFG0 + 8'h08, 32'h04);
    settle();
    chk("keep_high", 1, pad_i[2]);
    wr(GP_PINCFG0 + 8'h08, 32'h08);
    settle();
    chk("pull_dn", 1, pull_dn[2]);
    wr(GP_PINCFG0 + 8'h08, 32'h04);
    settle();
    chk("keep_low", 0, pad_i[2]);
    chk("keep_pull_dn", 1, pull_dn[2]);
    wr(GP_OUTCLR, 32'h04);
    wr(GP_DIRSET, 32'h04);
    wr(GP_PINCFG0 + 8'h08, 32'h14);
    settle();
    chk("wand_low", 0, pad_oe_n[2]);
    wr(GP_OUTSET, 32'h04);
    settle();
    chk("wand_release", 1, pad_oe_n[2]);
    chk("wand_pad", 1, pad_i[2]);
    wr(GP_PINCFG0 + 8'h08, 32'h10);
    settle();
    chk("wor_drive", 0, pad_oe_n[2]);
    wr(GP_OUTCLR, 32'h04);
    settle();
    chk("wor_release", 1, pad_oe_n[2]);
    chk("wor_pad", 0, pad_i[2]);
    wr(GP_DIRCLR, 32'h04);
    @(posedge clk);
    ext_en <= 8'hff;
    wr(GP_DIRSET, 32'h80);
    wr(GP_CTRL, 1);
    for (int e = 1; e >= 0; e--) begin
      @(posedge clk);
      ev0_i <= e[0];
      settle();
      chk("event_pin7", e, pad_o[7]);
    end
    wr(GP_CTRL, 2);
    settle();
    v[0] = pad_o[7];
    @(negedge clk);
    chk("clk_out", {31'h0, !v[0]}, pad_o[7]);
    // Reset in mid-run while pin 7 is driven
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("oe_mid_reset", 32'hff, pad_oe_n);
    @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, GP_DIR, 0, q);
    chk("dir_after_reset", 0, q);
    bus(1'b0, 8'hfc, 0, q);
    chk("unmapped", 0, q);
    results();
  end
endmodule : gp_port_bench
`default_nettype wire
